// file: verilog/csp_pkg.sv
package csp_pkg;

   // ************************************************************
   // register map, byte addresses on the 8-bit wishbone address
   // ************************************************************
   localparam logic [7:0] CSP_ADR_REF_SEL = 8'h00;
   localparam logic [7:0] CSP_ADR_MULT = 8'h04;
   localparam logic [7:0] CSP_ADR_DIV = 8'h08;
   localparam logic [7:0] CSP_ADR_POST = 8'h0C;
   localparam logic [7:0] CSP_ADR_PEND = 8'h10;
   // per generated clock: source at base + 8*i, prescale at base + 8*i + 4
   localparam logic [7:0] CSP_ADR_GEN_BASE = 8'h80;
   localparam logic [7:0] CSP_GEN_MASK = 8'h83;
   localparam int CSP_GEN_IDX_LSB = 3;
   localparam int CSP_GEN_PRE_BIT = 2;

   // ************************************************************
   // widths and counts
   // ************************************************************
   localparam int CSP_NUM_CLK = 16;
   localparam int CSP_NUM_FAST = 4;
   localparam int CSP_CODE_W = 6;
   localparam int CSP_ACC_W = 11;
   localparam logic [10:0] CSP_ACC_LIMIT = 11'h7C0;

   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic CSP_RST_REF_SEL = 1'b0;
   localparam logic [5:0] CSP_RST_MULT = 6'h01;
   localparam logic [5:0] CSP_RST_DIV = 6'h01;
   localparam logic [1:0] CSP_RST_POST = 2'h0;
   localparam logic [1:0] CSP_RST_SRC = 2'h1;
   localparam logic [2:0] CSP_RST_PRE = 3'h0;
   localparam logic [2:0] CSP_FAST_PRE_MASK = 3'h3;

   // ************************************************************
   // clock source codes
   // ************************************************************
   typedef enum logic [1:0] {
      CSP_SRC_PLL = 2'h0,
      CSP_SRC_RC = 2'h1,
      CSP_SRC_XTAL = 2'h2,
      CSP_SRC_OFF = 2'h3
   } csp_src_t;

   // total pll divide: divider code times 2 to the power of the post code
   function automatic logic [8:0] csp_pll_div(input logic [5:0] n, input logic [1:0] post);
      return {3'h0, n} << post;
   endfunction : csp_pll_div

   // last count of a power-of-two prescaler
   function automatic logic [6:0] csp_ratio_last(input logic [2:0] pre);
      return 7'((8'h01 << pre) - 8'h01);
   endfunction : csp_ratio_last

endpackage : csp_pkg

// file: verilog/csp_src_if.sv
`timescale 1ns/1ps
// source ticks shared by the pll and every clock divider
interface csp_src_if;
   logic pll_tick;
   logic rc_tick;
   logic xtal_tick;

   modport pll_drv (output pll_tick, input rc_tick, input xtal_tick);
   modport sink (input pll_tick, input rc_tick, input xtal_tick);
endinterface : csp_src_if

// file: verilog/csp_pll.sv
`timescale 1ns/1ps
module csp_pll
   import csp_pkg::*;
(
   // clock and reset
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic ce_in,
   // source ticks
   csp_src_if.pll_drv src,
   // settings
   input wire logic ref_sel_in,
   input wire logic [5:0] mult_in,
   input wire logic [5:0] div_in,
   input wire logic [1:0] post_in
);

   typedef struct packed {
      logic [10:0] acc;
      logic tick;
   } csp_pll_st_t;

   localparam csp_pll_st_t CSP_PLL_RST = '{acc: '0, tick: 1'b0};

   csp_pll_st_t st;
   csp_pll_st_t next_st;
   logic ref_tick;
   logic [8:0] dval;
   logic [10:0] dv;

   // ************************************************************
   // rate synthesis
   // ************************************************************
   // each reference edge adds the multiplier, each output tick removes
   // the total divide, so the average tick rate is ref * m / (n * od)
   assign ref_tick = ref_sel_in ? src.rc_tick : src.xtal_tick; // RULE1
   assign dval = csp_pll_div(div_in, post_in); // RULE2 RULE3
   assign dv = {2'h0, dval};

   always_comb begin
      next_st = st;
      next_st.tick = 1'b0;
      if (dval == 9'h000) begin
         next_st.acc = '0; // a zero divider stops the output
      end else begin
         if (st.acc >= dv) begin
            next_st.acc = st.acc - dv; // RULE2
            next_st.tick = 1'b1;
         end
         // saturate: above the clock rate ticks are simply lost
         if (ref_tick && st.acc < CSP_ACC_LIMIT) begin
            next_st.acc = next_st.acc + {5'h00, mult_in}; // RULE2
         end
      end
   end

   // state register
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         st <= CSP_PLL_RST;
      end else if (ce_in) begin
         st <= next_st;
      end
   end

   assign src.pll_tick = st.tick;

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);

   property p_ref_only;
      ce_in && !(ref_sel_in ? src.rc_tick : src.xtal_tick) |=> st.acc <= $past(st.acc);
   endproperty
   a_ref_only: assert property (p_ref_only) else $error("acc grew without ref edge"); // RULE1

   property p_drain;
      ce_in && !ref_tick && dval != 9'h000 && st.acc >= dv
         |=> st.tick && st.acc == $past(st.acc) - $past(dv);
   endproperty
   a_drain: assert property (p_drain) else $error("pll tick did not drain divide"); // RULE2

   property p_post_div8;
      post_in == 2'h3 |-> dval == 9'(div_in * 4'h8);
   endproperty
   a_post_div8: assert property (p_post_div8) else $error("post divide 8 wrong"); // RULE3

   property p_post_div2;
      post_in == 2'h1 |-> dval == 9'(div_in * 4'h2);
   endproperty
   a_post_div2: assert property (p_post_div2) else $error("post divide 2 wrong"); // RULE3

endmodule : csp_pll

// file: verilog/csp_gen_div.sv
`timescale 1ns/1ps
module csp_gen_div
   import csp_pkg::*;
(
   // clock and reset
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic ce_in,
   // source ticks
   csp_src_if.sink src,
   // settings from software
   input wire logic [1:0] sel_in,
   input wire logic [2:0] pre_in,
   // outputs
   output logic clk_en_out,
   output logic pending_out
);

   typedef struct packed {
      logic [6:0] cnt;
      logic [1:0] sel;
      logic [2:0] pre;
      logic pulse;
   } csp_div_st_t;

   localparam csp_div_st_t CSP_DIV_RST =
      '{cnt: '0, sel: CSP_RST_SRC, pre: CSP_RST_PRE, pulse: 1'b0};

   csp_div_st_t st;
   csp_div_st_t next_st;
   logic tick;
   logic wrap;

   // ************************************************************
   // source select and prescaler
   // ************************************************************
   always_comb begin
      unique case (csp_src_t'(st.sel)) // RULE4
         CSP_SRC_PLL: tick = src.pll_tick;
         CSP_SRC_RC: tick = src.rc_tick;
         CSP_SRC_XTAL: tick = src.xtal_tick;
         CSP_SRC_OFF: tick = 1'b0;
      endcase
   end

   assign wrap = tick && st.cnt == csp_ratio_last(st.pre); // RULE5 RULE6

   // new settings are only taken at the end of a full output period, so a
   // change never shortens a period; a stopped clock takes them at once
   always_comb begin
      next_st = st;
      next_st.pulse = 1'b0;
      if (st.sel == CSP_SRC_OFF) begin
         next_st.sel = sel_in; // RULE7
         next_st.pre = pre_in;
         next_st.cnt = '0;
      end else if (wrap) begin
         next_st.pulse = 1'b1; // RULE5 RULE6
         next_st.cnt = '0;
         next_st.sel = sel_in; // RULE7
         next_st.pre = pre_in;
      end else if (tick) begin
         next_st.cnt = st.cnt + 7'h01;
      end
   end

   // state register
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         st <= CSP_DIV_RST;
      end else if (ce_in) begin
         st <= next_st;
      end
   end

   assign clk_en_out = st.pulse;
   assign pending_out = (st.sel != sel_in) || (st.pre != pre_in);

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);

   sequence s_wrap;
      ce_in && tick && st.cnt == csp_ratio_last(st.pre) && st.sel != CSP_SRC_OFF;
   endsequence

   property p_wrap;
      s_wrap |=> st.pulse && st.cnt == 7'h00;
   endproperty
   a_wrap: assert property (p_wrap) else $error("prescaler missed its period end"); // RULE5 RULE6

   property p_no_early;
      ce_in && tick && st.cnt != csp_ratio_last(st.pre) && st.sel != CSP_SRC_OFF
         |=> !st.pulse && st.cnt == $past(st.cnt) + 7'h01;
   endproperty
   a_no_early: assert property (p_no_early) else $error("prescaler pulsed early"); // RULE5 RULE6

   property p_rc_source;
      st.pulse && $past(ce_in) && $past(st.sel) == CSP_SRC_RC |-> $past(src.rc_tick);
   endproperty
   a_rc_source: assert property (p_rc_source) else $error("rc clock pulse without rc tick"); // RULE4

   property p_hold_mid;
      ce_in && st.sel != CSP_SRC_OFF && !wrap
         |=> st.sel == $past(st.sel) && st.pre == $past(st.pre);
   endproperty
   a_hold_mid: assert property (p_hold_mid) else $error("setting changed mid period"); // RULE7

endmodule : csp_gen_div

// file: verilog/csp_top.sv
// How it works
// RULE1: a register picks crystal or rc oscillator as the pll reference
// RULE2: pll output rate is reference times multiplier over divider and post divider
// RULE3: post divider code k divides by two to the power k: 1, 2, 4, 8
// RULE4: every generated clock picks pll, rc or crystal through its own register
// RULE5: core bus, converter and both serial clocks prescale by 1, 2, 4, 8
// RULE6: timer, pulse width, calendar, watchdog clocks prescale by 1 to 128
// RULE7: source or prescale changes apply at period ends, never truncating a period
//
// Decided for this implementation: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
module csp_top
   import csp_pkg::*;
(
   // clock, reset, enable
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic ce_in,
   // wishbone slave
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [7:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   // oscillator clocks, sampled as synchronous levels
   input wire logic crystal_osc_clock_in,
   input wire logic rc_osc_clock_in,
   // generated clocks as one-cycle enables
   output logic pll_output_tick_out,
   output logic core_bus_clock_out,
   output logic converter_clock_out,
   output logic sync_serial_clock_out,
   output logic async_serial_clock_out,
   output logic dual_timer_clock_a_out,
   output logic dual_timer_clock_b_out,
   output logic [7:0] pulse_width_clock_out,
   output logic calendar_clock_out,
   output logic watchdog_tick_clock_out
);

   typedef struct packed {
      logic ref_sel;
      logic [5:0] mult;
      logic [5:0] div;
      logic [1:0] post;
      logic [15:0][1:0] src;
      logic [15:0][2:0] pre;
      logic ack;
      logic [31:0] rdata;
      logic xtal_prev;
      logic rc_prev;
   } csp_top_st_t;

   localparam csp_top_st_t CSP_TOP_RST = '{
      ref_sel: CSP_RST_REF_SEL,
      mult: CSP_RST_MULT,
      div: CSP_RST_DIV,
      post: CSP_RST_POST,
      src: {CSP_NUM_CLK{CSP_RST_SRC}},
      pre: {CSP_NUM_CLK{CSP_RST_PRE}},
      ack: 1'b0,
      rdata: '0,
      xtal_prev: 1'b0,
      rc_prev: 1'b0
   };

   csp_top_st_t st;
   csp_top_st_t next_st;
   logic [15:0] clk_en;
   logic [15:0] pend;
   logic req;
   logic wr;
   logic [5:0] dec;
   logic [31:0] rdv;

   // oscillator and pll ticks, shared by every divider
   csp_src_if src_bus ();

   // ************************************************************
   // address decode
   // ************************************************************
   // returns {per-clock hit, prescale word, clock index}
   function automatic logic [5:0] csp_decode(input logic [7:0] adr);
      logic hit;
      hit = (adr & CSP_GEN_MASK) == CSP_ADR_GEN_BASE;
      return {hit, adr[CSP_GEN_PRE_BIT], adr[CSP_GEN_IDX_LSB +: 4]};
   endfunction : csp_decode

   assign req = wb_cyc_in && wb_stb_in;
   assign dec = csp_decode(wb_adr_in);
   // a write lands on the edge where the master sees ack
   assign wr = req && st.ack && wb_we_in && wb_sel_in[0];

   // ************************************************************
   // read mux
   // ************************************************************
   // unmapped addresses answer normally with zero data
   always_comb begin
      rdv = 32'h0000_0000;
      if (dec[5]) begin
         if (dec[4]) begin
            rdv = {29'h0, st.pre[dec[3:0]]};
         end else begin
            rdv = {30'h0, st.src[dec[3:0]]};
         end
      end else begin
         case (wb_adr_in)
            CSP_ADR_REF_SEL: rdv = {31'h0, st.ref_sel};
            CSP_ADR_MULT: rdv = {26'h0, st.mult};
            CSP_ADR_DIV: rdv = {26'h0, st.div};
            CSP_ADR_POST: rdv = {30'h0, st.post};
            CSP_ADR_PEND: rdv = {16'h0, pend};
            default: rdv = 32'h0000_0000;
         endcase
      end
   end

   // ************************************************************
   // bus slave and configuration registers
   // ************************************************************
   always_comb begin
      next_st = st;
      next_st.xtal_prev = crystal_osc_clock_in;
      next_st.rc_prev = rc_osc_clock_in;
      next_st.ack = req && !st.ack; // one wait cycle, then a single ack
      if (req && !st.ack) begin
         next_st.rdata = rdv;
      end
      if (wr) begin
         if (dec[5]) begin
            if (dec[4]) begin
               // fast clocks keep only the two low prescale bits
               if (dec[3:0] < 4'(CSP_NUM_FAST)) begin
                  next_st.pre[dec[3:0]] = wb_dat_in[2:0] & CSP_FAST_PRE_MASK; // RULE5
               end else begin
                  next_st.pre[dec[3:0]] = wb_dat_in[2:0]; // RULE6
               end
            end else begin
               next_st.src[dec[3:0]] = wb_dat_in[1:0]; // RULE4
            end
         end else begin
            case (wb_adr_in)
               CSP_ADR_REF_SEL: next_st.ref_sel = wb_dat_in[0]; // RULE1
               CSP_ADR_MULT: next_st.mult = wb_dat_in[5:0]; // RULE2
               CSP_ADR_DIV: next_st.div = wb_dat_in[5:0]; // RULE2
               CSP_ADR_POST: next_st.post = wb_dat_in[1:0]; // RULE3
               default: next_st.ref_sel = st.ref_sel;
            endcase
         end
      end
   end

   // state register
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         st <= CSP_TOP_RST;
      end else if (ce_in) begin
         st <= next_st;
      end
   end

   // both bus outputs come straight from flip-flops
   assign wb_ack_out = st.ack;
   assign wb_dat_out = st.rdata;

   // ************************************************************
   // oscillator edges, pll and dividers
   // ************************************************************
   // rising-edge ticks; the oscillators must run slower than half clk_in
   assign src_bus.xtal_tick = crystal_osc_clock_in && !st.xtal_prev;
   assign src_bus.rc_tick = rc_osc_clock_in && !st.rc_prev;

   csp_pll u_pll (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .ce_in(ce_in),
      .src(src_bus.pll_drv),
      .ref_sel_in(st.ref_sel),
      .mult_in(st.mult),
      .div_in(st.div),
      .post_in(st.post)
   );

   // one divider per generated clock, each with its own source and prescale
   for (genvar i = 0; i < CSP_NUM_CLK; i++) begin : g_div
      csp_gen_div u_div (
         .clk_in(clk_in),
         .rstn_in(rstn_in),
         .ce_in(ce_in),
         .src(src_bus.sink),
         .sel_in(st.src[i]),
         .pre_in(st.pre[i]),
         .clk_en_out(clk_en[i]),
         .pending_out(pend[i])
      );
   end

   // output mapping by clock index
   assign pll_output_tick_out = src_bus.pll_tick;
   assign core_bus_clock_out = clk_en[0];
   assign converter_clock_out = clk_en[1];
   assign sync_serial_clock_out = clk_en[2];
   assign async_serial_clock_out = clk_en[3];
   assign dual_timer_clock_a_out = clk_en[4];
   assign dual_timer_clock_b_out = clk_en[5];
   assign pulse_width_clock_out = clk_en[13:6];
   assign calendar_clock_out = clk_en[14];
   assign watchdog_tick_clock_out = clk_en[15];

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);

   property p_ack_single;
      ce_in && wb_ack_out |=> !wb_ack_out;
   endproperty
   a_ack_single: assert property (p_ack_single) else $error("ack held two cycles");

   property p_ref_write;
      ce_in && wr && !dec[5] && wb_adr_in == CSP_ADR_REF_SEL
         |=> st.ref_sel == $past(wb_dat_in[0]);
   endproperty
   a_ref_write: assert property (p_ref_write) else $error("ref select not stored"); // RULE1

   property p_src_write;
      ce_in && wr && dec[5] && !dec[4] |=> st.src[$past(dec[3:0])] == $past(wb_dat_in[1:0]);
   endproperty
   a_src_write: assert property (p_src_write) else $error("source select not stored"); // RULE4

   property p_fast_pre;
      (st.pre[0][2] | st.pre[1][2] | st.pre[2][2] | st.pre[3][2]) == 1'b0;
   endproperty
   a_fast_pre: assert property (p_fast_pre) else $error("fast prescale beyond 8"); // RULE5

   property p_slow_pre;
      ce_in && wr && dec[5] && dec[4] && dec[3:0] >= 4'(CSP_NUM_FAST)
         |=> st.pre[$past(dec[3:0])] == $past(wb_dat_in[2:0]);
   endproperty
   a_slow_pre: assert property (p_slow_pre) else $error("slow prescale not stored"); // RULE6

   // a request is taken while ack is low; ack and data follow a cycle later
   sequence s_bus_take;
      ce_in && req && !st.ack;
   endsequence

   property p_ack_next;
      s_bus_take |=> wb_ack_out;
   endproperty
   a_ack_next: assert property (p_ack_next) else $error("no ack after wait cycle");

   property p_read_data;
      s_bus_take |=> wb_dat_out == $past(rdv);
   endproperty
   a_read_data: assert property (p_read_data) else $error("read data not captured");

   // no stray ack once the master has let go
   property p_ack_idle;
      ce_in && !req |=> !wb_ack_out;
   endproperty
   a_ack_idle: assert property (p_ack_idle) else $error("ack without request");

   // holes in the map read as zero, so software may probe safely
   property p_hole_zero;
      ce_in && req && !st.ack && !dec[5] && wb_adr_in > CSP_ADR_PEND
         |=> wb_dat_out == 32'h0000_0000;
   endproperty
   a_hole_zero: assert property (p_hole_zero) else $error("hole read not zero");

   property p_mult_write;
      ce_in && wr && !dec[5] && wb_adr_in == CSP_ADR_MULT
         |=> st.mult == $past(wb_dat_in[5:0]);
   endproperty
   a_mult_write: assert property (p_mult_write) else $error("mult not stored"); // RULE2

   property p_div_write;
      ce_in && wr && !dec[5] && wb_adr_in == CSP_ADR_DIV
         |=> st.div == $past(wb_dat_in[5:0]);
   endproperty
   a_div_write: assert property (p_div_write) else $error("div not stored"); // RULE2

   property p_post_write;
      ce_in && wr && !dec[5] && wb_adr_in == CSP_ADR_POST
         |=> st.post == $past(wb_dat_in[1:0]);
   endproperty
   a_post_write: assert property (p_post_write) else $error("post not stored"); // RULE3

   // fast clocks lose bit 2 on the way in, so divide by 16 is out of reach
   property p_fast_write;
      ce_in && wr && dec[5] && dec[4] && dec[3:0] < 4'(CSP_NUM_FAST)
         |=> st.pre[$past(dec[3:0])] == {1'b0, $past(wb_dat_in[1:0])};
   endproperty
   a_fast_write: assert property (p_fast_write) else $error("fast prescale not stored"); // RULE5

   // a write with lane 0 off leaves every clock setting alone
   property p_lane_off;
      ce_in && req && st.ack && wb_we_in && !wb_sel_in[0]
         |=> st.src == $past(st.src) && st.pre == $past(st.pre);
   endproperty
   a_lane_off: assert property (p_lane_off) else $error("write landed with lane 0 off"); // RULE4

endmodule : csp_top

// file: tb/tb_csp_top.sv
`timescale 1ns/1ps
module tb_csp_top
   import csp_pkg::*;
();
   // ********************
   // stimulus and observed signals
   // ********************
   typedef struct {logic [7:0] adr; logic we; logic [31:0] d; logic [31:0] exp;} csp_tb_row_t;
   logic clk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic ce_in = 1'b1;
   logic wb_cyc_in = 1'b0;
   logic wb_stb_in = 1'b0;
   logic wb_we_in = 1'b0;
   logic [7:0] wb_adr_in = 8'h00;
   logic [3:0] wb_sel_in = 4'h0;
   logic [31:0] wb_dat_in = 32'h0;
   logic [31:0] wb_dat_out;
   logic wb_ack_out;
   logic xtal_osc = 1'b0;
   logic rc_osc = 1'b0;
   logic pll_tick, core, conv, sync, async, tim_a, tim_b, cal, wdog;
   logic [7:0] pwm;
   logic [15:0] gen;
   int failures = 0;
   int compares = 0;
   int cyc_cnt = 0;
   int rcnt = 0;
   int xcnt = 0;
   logic [31:0] rd;
   csp_tb_row_t rows [0:25] = '{
      '{8'h00, 1'b0, 32'h0, 32'h0}, '{8'h04, 1'b0, 32'h0, 32'h1}, '{8'h08, 1'b0, 32'h0, 32'h1},
      '{8'h0C, 1'b0, 32'h0, 32'h0}, '{8'h10, 1'b0, 32'h0, 32'h0}, '{8'h80, 1'b0, 32'h0, 32'h1},
      '{8'h84, 1'b0, 32'h0, 32'h0}, '{8'hFC, 1'b0, 32'h0, 32'h0}, '{8'hF8, 1'b0, 32'h0, 32'h1},
      '{8'h14, 1'b0, 32'h0, 32'h0}, '{8'h81, 1'b0, 32'h0, 32'h0}, '{8'h84, 1'b1, 32'h7, 32'h0},
      '{8'h84, 1'b0, 32'h0, 32'h3}, '{8'hAC, 1'b1, 32'hFF, 32'h0}, '{8'hAC, 1'b0, 32'h0, 32'h7},
      '{8'h0C, 1'b1, 32'hFF, 32'h0}, '{8'h0C, 1'b0, 32'h0, 32'h3},
      '{8'h04, 1'b1, 32'hFFFFFFFF, 32'h0}, '{8'h04, 1'b0, 32'h0, 32'h3F},
      '{8'h00, 1'b1, 32'h1, 32'h0}, '{8'h00, 1'b0, 32'h0, 32'h1}, '{8'h14, 1'b1, 32'h5, 32'h0},
      '{8'h14, 1'b0, 32'h0, 32'h0}, '{8'h04, 1'b1, 32'h1, 32'h0}, '{8'h0C, 1'b1, 32'h0, 32'h0},
      '{8'h00, 1'b1, 32'h0, 32'h0}};
   // ref select, multiplier, divider, post code
   logic [14:0] pll_tab [0:7] = '{{1'b0, 6'h01, 6'h01, 2'h0}, {1'b1, 6'h01, 6'h01, 2'h0},
      {1'b0, 6'h03, 6'h02, 2'h0}, {1'b0, 6'h04, 6'h01, 2'h2}, {1'b0, 6'h01, 6'h01, 2'h1},
      {1'b0, 6'h01, 6'h01, 2'h3}, {1'b0, 6'h00, 6'h01, 2'h0}, {1'b0, 6'h3F, 6'h3F, 2'h0}};

   assign gen = {wdog, cal, pwm, tim_b, tim_a, async, sync, conv, core};

   csp_top i_csp_top (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce_in),
      .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
      .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
      .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
      .crystal_osc_clock_in(xtal_osc), .rc_osc_clock_in(rc_osc),
      .pll_output_tick_out(pll_tick), .core_bus_clock_out(core), .converter_clock_out(conv),
      .sync_serial_clock_out(sync), .async_serial_clock_out(async),
      .dual_timer_clock_a_out(tim_a), .dual_timer_clock_b_out(tim_b),
      .pulse_width_clock_out(pwm), .calendar_clock_out(cal), .watchdog_tick_clock_out(wdog));

   // ********************
   // clock and oscillators
   // ********************
   initial begin
      forever #5 clk_in = ~clk_in;
   end

   // rc period 4 cycles, crystal 6: both below half the system rate, as sampling needs
   always @(posedge clk_in) begin
      cyc_cnt <= cyc_cnt + 1;
      rcnt <= (rcnt == 1) ? 0 : rcnt + 1;
      xcnt <= (xcnt == 2) ? 0 : xcnt + 1;
      if (rcnt == 1) rc_osc <= ~rc_osc;
      if (xcnt == 2) xtal_osc <= ~xtal_osc;
   end

   // ********************
   // shared tasks
   // ********************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic tally_and_finish();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : tally_and_finish

   // one classic cycle; entered just after an edge, leaves one idle cycle behind it
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d,
                     input logic [3:0] sel, output logic [31:0] q);
      int n;
      n = 0;
      wb_cyc_in <= 1'b1;
      wb_stb_in <= 1'b1;
      wb_we_in <= we;
      wb_adr_in <= adr;
      wb_dat_in <= d;
      wb_sel_in <= sel;
      do begin
         @(posedge clk_in);
         n++;
      end while (wb_ack_out !== 1'b1 && n < 50);
      if (n >= 50) begin
         failures++;
         tally_and_finish();
      end
      q = wb_dat_out;
      wb_cyc_in <= 1'b0;
      wb_stb_in <= 1'b0;
      wb_we_in <= 1'b0;
      @(posedge clk_in);
   endtask : wb

   task automatic wr(input logic [7:0] adr, input logic [31:0] d);
      wb(1'b1, adr, d, 4'hF, rd);
   endtask : wr

   task automatic rdc(input logic [7:0] adr, input logic [31:0] exp);
      wb(1'b0, adr, 32'h0, 4'hF, rd);
      check(rd, exp);
   endtask : rdc

   // bounded wait for one pulse of generated clock idx
   task automatic wait_pulse(input int idx);
      int n;
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
      end while (gen[idx] !== 1'b1 && n < 2000);
      if (n >= 2000) begin
         failures++;
         tally_and_finish();
      end
   endtask : wait_pulse

   task automatic measure(input int idx, output int per);
      int t0;
      wait_pulse(idx);
      t0 = cyc_cnt;
      wait_pulse(idx);
      per = cyc_cnt - t0;
   endtask : measure

   // ********************
   // main sequence
   // ********************
   initial begin
      int per, t0, cnt, exp;
      logic [1:0] src, po;
      logic [2:0] pre;
      logic [5:0] m, n;
      logic rs;
      repeat (12) @(posedge clk_in);
      rstn_in <= 1'b1;
      @(posedge clk_in);
      // register rows: reset values, field widths, unmapped places
      foreach (rows[i]) begin
         wb(rows[i].we, rows[i].adr, rows[i].d, 4'hF, rd);
         if (!rows[i].we) check(rd, rows[i].exp);
      end
      // the wide multiplier rows leave a backlog in the pll accumulator: let it drain
      repeat (300) @(posedge clk_in);
      // every clock, all three sources, every prescale step across the set
      for (int i = 0; i < CSP_NUM_CLK; i++) begin
         src = 2'(i % 3);
         pre = (i < CSP_NUM_FAST) ? 3'(i % 4) : 3'((i - CSP_NUM_FAST) % 8);
         wr(8'(8'h80 + 8 * i), {30'h0, src});
         wr(8'(8'h84 + 8 * i), {29'h0, pre});
         wait_pulse(i);
         measure(i, per);
         check(32'(per), 32'(((src == 2'h1) ? 4 : 6) << pre));
      end
      // prescale change mid-period: old period must finish whole, then new rate
      wait_pulse(11);
      t0 = cyc_cnt;
      wr(8'hDC, 32'h0);
      rdc(CSP_ADR_PEND, 32'h800);
      wait_pulse(11);
      check(32'(cyc_cnt - t0), 32'h300);
      measure(11, per);
      check(32'(per), 32'h6);
      rdc(CSP_ADR_PEND, 32'h0);
      // clock switched off gives no pulses
      wr(8'h98, 32'h3);
      wait_pulse(3); // off is adopted only at the end of the running period
      cnt = 0;
      repeat (100) begin
         @(posedge clk_in);
         if (gen[3] === 1'b1) cnt++;
      end
      check(32'(cnt), 32'h0);
      // byte lane 0 disabled: write dropped
      wb(1'b1, 8'h80, 32'h2, 4'h0, rd);
      rdc(8'h80, 32'h0);
      // pll rate over a window; saturation and remainder allow a small slack
      foreach (pll_tab[k]) begin
         {rs, m, n, po} = pll_tab[k];
         wr(CSP_ADR_REF_SEL, {31'h0, rs});
         wr(CSP_ADR_MULT, {26'h0, m});
         wr(CSP_ADR_DIV, {26'h0, n});
         wr(CSP_ADR_POST, {30'h0, po});
         repeat (60) @(posedge clk_in);
         cnt = 0;
         repeat (600) begin
            @(posedge clk_in);
            if (pll_tick === 1'b1) cnt++;
         end
         exp = ((rs ? 150 : 100) * int'(m)) / (int'(n) << po);
         check(32'(cnt <= exp + 2 && cnt + 2 >= exp), 32'h1);
      end
      // second reset in mid-run restores defaults
      rstn_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      check(32'(gen), 32'h0);
      rstn_in <= 1'b1;
      @(posedge clk_in);
      rdc(CSP_ADR_REF_SEL, 32'h0);
      rdc(8'h98, 32'h1);
      rdc(8'h84, 32'h0);
      measure(0, per);
      check(32'(per), 32'h4);
      // clock enable low freezes the dividers: no pulse may appear
      ce_in <= 1'b0;
      cnt = 0;
      repeat (20) begin
         @(posedge clk_in);
         if (gen[0] === 1'b1) cnt++;
      end
      ce_in <= 1'b1;
      check(32'(cnt), 32'h0);
      wait_pulse(0);
      measure(0, per);
      check(32'(per), 32'h4);
      tally_and_finish();
   end
endmodule : tb_csp_top
